// ==== fnc_host.v ====
// host controller that drives a parallel nor flash through its pins
// Contract
// - reset byte exits identifier mode or timeout
// - identifier: three writes, then read low bits
// - program: three writes, then address and data
// - erases: five writes, then 10h or 30h
// - 98h enters query; reads until reset
// - write: chip and write enable low
`timescale 1ns/1ps
`include "fnc_consts.vh"
module fnc_host (
	input wire i_clk,
	input wire i_nrst,
	input wire i_req,
	input wire [3:0] i_op,
	input wire [20:0] i_addr,
	input wire [7:0] i_data,
	output reg o_busy,
	output reg o_done,
	output reg o_err,
	output reg [7:0] o_rdata,
	output reg o_erase_active,
	output reg o_erase_suspended,
	output wire [20:0] o_fl_addr,
	output wire [7:0] o_fl_dq_out,
	output wire o_fl_dq_oe_n,
	input wire [7:0] i_fl_dq,
	output wire o_fl_ce_n,
	output wire o_fl_oe_n,
	output wire o_fl_we_n,
	output reg o_fl_rst_n,
	input wire i_fl_ready_busy
);
	// reset pulse is a least time (round up), recovery likewise
	localparam [31:0] RP_W = (`FNC_T_RP_NS + `FNC_CLK_NS - 1) / `FNC_CLK_NS;
	localparam [31:0] RH_W = (`FNC_T_RH_NS + `FNC_CLK_NS - 1) / `FNC_CLK_NS;
	localparam [7:0] RP_CYC = RP_W[7:0];
	localparam [7:0] RH_CYC = RH_W[7:0];
	// one-hot states
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ISSUE = 6'h02;
	localparam [5:0] ST_WAIT = 6'h04;
	localparam [5:0] ST_ABORT = 6'h08;
	localparam [5:0] ST_RSTLO = 6'h10;
	localparam [5:0] ST_RSTHI = 6'h20;

	reg rst_s1_q; // reset release synchroniser
	reg rst_s2_q; // reset used by the rest of the design
	reg rb_s1_q; // ready/busy first stage
	reg rb_s2_q; // synchronised ready/busy
	reg rb_prev_q; // previous ready/busy, for the rising edge
	reg [5:0] state_q; // sequencer state
	reg [3:0] op_q; // accepted operation
	reg [20:0] addr_q; // accepted address
	reg [7:0] data_q; // accepted data
	reg [2:0] step_q; // index into the command sequence
	reg [1:0] kind_q; // kind of the bus cycle in flight
	reg [7:0] cnt_q; // reset pulse timer
	reg start_q; // one-cycle start to the bus engine
	reg cwr_q; // bus cycle is a write
	reg [20:0] caddr_q; // bus cycle address
	reg [7:0] cdata_q; // bus cycle write data
	wire bus_done; // bus cycle finished
	wire [7:0] bus_rdata; // byte captured by the last read
	wire [30:0] entry; // {kind, address, data} of the current step
	wire refuse; // request that must not reach the flash

	// sequence table: one bus step per index, ending in an end marker
	function [30:0] seq_step;
		input [3:0] op;
		input [2:0] step;
		input [20:0] a;
		input [7:0] d;
		reg [20:0] sect; // sector base address
		begin
			sect = {a[`FNC_SECT_HI:`FNC_SECT_LO], 16'h0000};
			seq_step = {`FNC_K_END, 21'h000000, 8'h00};
			// two shared unlock steps for the identifier, protect, program and erase commands
			if (step == 3'h0 && op >= `FNC_OP_IDENT && op <= `FNC_OP_SECT)
				seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_UNLOCK1};
			else if (step == 3'h1 && op >= `FNC_OP_IDENT && op <= `FNC_OP_SECT)
				seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_UNLOCK2};
			else begin
				case (op)
					`FNC_OP_READ: begin
						if (step == 3'h0)
							seq_step = {`FNC_K_RD, a, 8'h00};
					end
					`FNC_OP_RESET: begin
						if (step == 3'h0)
							seq_step = {`FNC_K_WR, a, `FNC_CMD_RESET};
					end
					`FNC_OP_IDENT, `FNC_OP_PROT: begin
						// read one code, then leave identifier mode
						if (step == 3'h2)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_IDENT};
						else if (step == 3'h3 && op == `FNC_OP_IDENT)
							seq_step = {`FNC_K_RD, 19'h00000, a[1:0], 8'h00};
						else if (step == 3'h3)
							seq_step = {`FNC_K_RD, sect[20:16], `FNC_PROT_LOW, 8'h00};
						else if (step == 3'h4)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_RESET};
					end
					`FNC_OP_PROG: begin
						if (step == 3'h2)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_PROG};
						else if (step == 3'h3)
							seq_step = {`FNC_K_WR, a, d};
						else if (step == 3'h4)
							seq_step = {`FNC_K_POLL, a, 8'h00};
					end
					`FNC_OP_CHIP, `FNC_OP_SECT: begin
						if (step == 3'h2)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_ERASE_SETUP};
						else if (step == 3'h3)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_UNLOCK1};
						else if (step == 3'h4)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_UNLOCK2};
						else if (step == 3'h5 && op == `FNC_OP_CHIP)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_CHIP};
						else if (step == 3'h5)
							seq_step = {`FNC_K_WR, sect, `FNC_CMD_SECT};
						else if (step == 3'h6 && op == `FNC_OP_CHIP)
							seq_step = {`FNC_K_POLL, 21'h000000, 8'h00};
					end
					`FNC_OP_SUSP: begin
						if (step == 3'h0)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_SUSP};
					end
					`FNC_OP_RESUME: begin
						if (step == 3'h0)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_RESUME};
					end
					`FNC_OP_QUERY: begin
						// the table is read at the caller's address, 40h-4Ch and up
						if (step == 3'h0)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_QUERY};
						else if (step == 3'h1)
							seq_step = {`FNC_K_RD, a, 8'h00};
						else if (step == 3'h2)
							seq_step = {`FNC_K_WR, `FNC_UNLOCK_ADDR, `FNC_CMD_RESET};
					end
					default: begin
						seq_step = {`FNC_K_END, 21'h000000, 8'h00};
					end
				endcase
			end
		end
	endfunction

	assign entry = seq_step(op_q, step_q, addr_q, data_q);

	// suspend/resume only against a running or suspended sector erase;
	// nothing but reads, suspend and hardware reset may cut into a running erase
	assign refuse = (i_op > `FNC_OP_HWRST) ||
		(i_op == `FNC_OP_SUSP && !(o_erase_active && !o_erase_suspended)) ||
		(i_op == `FNC_OP_RESUME && !o_erase_suspended) ||
		(o_erase_active && !o_erase_suspended && i_op != `FNC_OP_READ &&
		i_op != `FNC_OP_SUSP && i_op != `FNC_OP_HWRST) ||
		(o_erase_suspended && (i_op == `FNC_OP_CHIP ||
		i_op == `FNC_OP_SECT));

	// reset release through two flip-flops
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// bus cycle engine owns the address, data and strobe pins
	fnc_bus_cycle u_cyc (
		.i_clk(i_clk),
		.i_nrst(rst_s2_q),
		.i_start(start_q),
		.i_wr(cwr_q),
		.i_addr(caddr_q),
		.i_wdata(cdata_q),
		.i_fl_dq(i_fl_dq),
		.o_done(bus_done),
		.o_rdata(bus_rdata),
		.o_fl_addr(o_fl_addr),
		.o_fl_dq_out(o_fl_dq_out),
		.o_fl_dq_oe_n(o_fl_dq_oe_n),
		.o_fl_ce_n(o_fl_ce_n),
		.o_fl_oe_n(o_fl_oe_n),
		.o_fl_we_n(o_fl_we_n)
	);

	// request sequencer
	always @(posedge i_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			// pin idles at ready, so a low reset value would fake a rise
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
			rb_prev_q <= 1'b1;
			state_q <= ST_IDLE;
			op_q <= `FNC_OP_READ;
			addr_q <= 21'h000000;
			data_q <= 8'h00;
			step_q <= 3'h0;
			kind_q <= `FNC_K_END;
			cnt_q <= 8'h00;
			start_q <= 1'b0;
			cwr_q <= 1'b0;
			caddr_q <= 21'h000000;
			cdata_q <= 8'h00;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_err <= 1'b0;
			o_rdata <= 8'h00;
			o_erase_active <= 1'b0;
			o_erase_suspended <= 1'b0;
			o_fl_rst_n <= 1'b1;
		end else begin
			rb_s1_q <= i_fl_ready_busy;
			rb_s2_q <= rb_s1_q;
			rb_prev_q <= rb_s2_q;
			start_q <= 1'b0;
			o_done <= 1'b0;
			// a running erase ends on ready rising; a later set below wins
			if (o_erase_active && !o_erase_suspended && rb_s2_q && !rb_prev_q)
				o_erase_active <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// requests are taken only here; busy hides the rest
					if (i_req) begin
						op_q <= i_op;
						addr_q <= i_addr;
						data_q <= i_data;
						step_q <= 3'h0;
						o_err <= 1'b0;
						if (refuse) begin
							o_done <= 1'b1;
							o_err <= 1'b1;
						end else if (i_op == `FNC_OP_HWRST) begin
							o_fl_rst_n <= 1'b0;
							cnt_q <= RP_CYC;
							o_busy <= 1'b1;
							state_q <= ST_RSTLO;
						end else begin
							o_busy <= 1'b1;
							state_q <= ST_ISSUE;
						end
					end
				end
				ST_ISSUE: begin
					// every step is emitted in table order, so no stray
					// write can knock the flash back to read mode
					if (entry[30:29] == `FNC_K_END) begin
						o_done <= 1'b1;
						o_busy <= 1'b0;
						if (op_q == `FNC_OP_SECT)
							o_erase_active <= 1'b1;
						if (op_q == `FNC_OP_SUSP)
							o_erase_suspended <= 1'b1;
						if (op_q == `FNC_OP_RESUME)
							o_erase_suspended <= 1'b0;
						state_q <= ST_IDLE;
					end else begin
						start_q <= 1'b1;
						cwr_q <= (entry[30:29] == `FNC_K_WR);
						caddr_q <= entry[28:8];
						cdata_q <= entry[7:0];
						kind_q <= entry[30:29];
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (bus_done) begin
						if (kind_q != `FNC_K_WR)
							o_rdata <= bus_rdata;
						if (kind_q != `FNC_K_POLL) begin
							step_q <= step_q + 3'h1;
							state_q <= ST_ISSUE;
						end else if (rb_s2_q) begin
							step_q <= step_q + 3'h1;
							state_q <= ST_ISSUE;
						end else if (bus_rdata[`FNC_TIMEOUT_BIT]) begin
							// timeout: only the reset byte brings it back
							o_err <= 1'b1;
							start_q <= 1'b1;
							cwr_q <= 1'b1;
							caddr_q <= `FNC_UNLOCK_ADDR;
							cdata_q <= `FNC_CMD_RESET;
							state_q <= ST_ABORT;
						end else begin
							state_q <= ST_ISSUE; // poll again
						end
					end
				end
				ST_ABORT: begin
					if (bus_done) begin
						o_done <= 1'b1;
						o_busy <= 1'b0;
						state_q <= ST_IDLE;
					end
				end
				ST_RSTLO: begin
					// hold the flash reset pin low for the full pulse
					if (cnt_q == 8'h01) begin
						o_fl_rst_n <= 1'b1;
						cnt_q <= RH_CYC;
						state_q <= ST_RSTHI;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_RSTHI: begin
					// flash is back in array read; erase state is gone
					if (cnt_q == 8'h01) begin
						o_erase_active <= 1'b0;
						o_erase_suspended <= 1'b0;
						o_done <= 1'b1;
						o_busy <= 1'b0;
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // fnc_host

// ==== fnc_consts.vh ====
// constants shared by the flash command host: opcodes, command bytes, timing
`ifndef FNC_CONSTS_VH
`define FNC_CONSTS_VH

// host-side operation codes on i_op
`define FNC_OP_READ 4'h0
`define FNC_OP_RESET 4'h1
`define FNC_OP_IDENT 4'h2
`define FNC_OP_PROT 4'h3
`define FNC_OP_PROG 4'h4
`define FNC_OP_CHIP 4'h5
`define FNC_OP_SECT 4'h6
`define FNC_OP_SUSP 4'h7
`define FNC_OP_RESUME 4'h8
`define FNC_OP_QUERY 4'h9
`define FNC_OP_HWRST 4'ha

// command bytes written to the flash
`define FNC_CMD_UNLOCK1 8'haa
`define FNC_CMD_UNLOCK2 8'h55
`define FNC_CMD_IDENT 8'h90
`define FNC_CMD_PROG 8'ha0
`define FNC_CMD_ERASE_SETUP 8'h80
`define FNC_CMD_CHIP 8'h10
`define FNC_CMD_SECT 8'h30
`define FNC_CMD_SUSP 8'hb0
`define FNC_CMD_RESUME 8'h30
`define FNC_CMD_QUERY 8'h98
`define FNC_CMD_RESET 8'hf0

// unlock cycles accept any address; zero is used
`define FNC_UNLOCK_ADDR 21'h000000
// low address that reads the protect status of a sector
`define FNC_PROT_LOW 16'h0002
// field positions inside the address and status byte
`define FNC_SECT_HI 20
`define FNC_SECT_LO 16
`define FNC_TIMEOUT_BIT 5

// sequence step kinds
`define FNC_K_WR 2'h0
`define FNC_K_RD 2'h1
`define FNC_K_POLL 2'h2
`define FNC_K_END 2'h3

// timing in ns
`define FNC_CLK_NS 20
`define FNC_T_WP_NS 35
`define FNC_T_ACC_NS 70
`define FNC_T_REC_NS 20
`define FNC_T_RP_NS 500
`define FNC_T_RH_NS 50
// synchroniser latency on the data pins, in cycles
`define FNC_SYNC_CYC 2

`endif

// ==== fnc_bus_cycle.v ====
// one asynchronous flash bus cycle (write or read) with pin timing
`timescale 1ns/1ps
`include "fnc_consts.vh"
module fnc_bus_cycle (
	input wire i_clk,
	input wire i_nrst,
	input wire i_start,
	input wire i_wr,
	input wire [20:0] i_addr,
	input wire [7:0] i_wdata,
	input wire [7:0] i_fl_dq,
	output reg o_done,
	output reg [7:0] o_rdata,
	output reg [20:0] o_fl_addr,
	output reg [7:0] o_fl_dq_out,
	output reg o_fl_dq_oe_n,
	output reg o_fl_ce_n,
	output reg o_fl_oe_n,
	output reg o_fl_we_n
);
	// least times round up to whole cycles
	localparam [31:0] WP_W = (`FNC_T_WP_NS + `FNC_CLK_NS - 1) / `FNC_CLK_NS;
	localparam [31:0] ACC_W = (`FNC_T_ACC_NS + `FNC_CLK_NS - 1) / `FNC_CLK_NS
		+ `FNC_SYNC_CYC;
	localparam [31:0] REC_W = (`FNC_T_REC_NS + `FNC_CLK_NS - 1) / `FNC_CLK_NS;
	localparam [3:0] WP_CYC = WP_W[3:0];
	localparam [3:0] ACC_CYC = ACC_W[3:0];
	localparam [3:0] REC_CYC = REC_W[3:0];
	// one-hot states
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_SET = 4'h2;
	localparam [3:0] ST_STB = 4'h4;
	localparam [3:0] ST_REC = 4'h8;

	reg [3:0] state_q; // cycle phase
	reg [3:0] cnt_q; // phase length counter
	reg wr_q; // current cycle is a write
	reg [7:0] dq_s1_q; // first sync stage, read only by the second
	reg [7:0] dq_s2_q; // synchronised data pins

	// cycle sequencer: setup, strobe, recovery
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_fl_addr <= 21'h000000;
			o_fl_dq_out <= 8'h00;
			o_fl_dq_oe_n <= 1'b1;
			o_fl_ce_n <= 1'b1;
			o_fl_oe_n <= 1'b1;
			o_fl_we_n <= 1'b1;
		end else begin
			dq_s1_q <= i_fl_dq;
			dq_s2_q <= dq_s1_q;
			o_done <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// address, data and chip select settle before the strobe
					if (i_start) begin
						wr_q <= i_wr;
						o_fl_addr <= i_addr;
						o_fl_dq_out <= i_wdata;
						o_fl_dq_oe_n <= ~i_wr;
						o_fl_ce_n <= 1'b0;
						o_fl_oe_n <= 1'b1;
						state_q <= ST_SET;
					end
				end
				ST_SET: begin
					// a write keeps output enable high and pulses write enable
					if (wr_q) begin
						o_fl_we_n <= 1'b0;
						cnt_q <= WP_CYC;
					end else begin
						o_fl_oe_n <= 1'b0;
						cnt_q <= ACC_CYC;
					end
					state_q <= ST_STB;
				end
				ST_STB: begin
					if (cnt_q == 4'h1) begin
						// data is still driven on the rising write edge
						o_fl_we_n <= 1'b1;
						o_fl_oe_n <= 1'b1;
						if (!wr_q)
							o_rdata <= dq_s2_q;
						cnt_q <= REC_CYC;
						state_q <= ST_REC;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				ST_REC: begin
					// hold and recovery, then release the bus
					if (cnt_q == 4'h1) begin
						o_fl_ce_n <= 1'b1;
						o_fl_dq_oe_n <= 1'b1;
						o_done <= 1'b1;
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 4'h1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule // fnc_bus_cycle

// ==== fnc_host_assertions.sv ====
// pin-level and request-refusal checks of the flash host, bound into fnc_host
`timescale 1ns/1ps
`include "fnc_consts.vh"
module fnc_host_assertions (
	input wire i_clk,
	input wire i_nrst,
	input wire i_req,
	input wire [3:0] i_op,
	input wire o_busy,
	input wire o_done,
	input wire o_err,
	input wire o_erase_active,
	input wire o_erase_suspended,
	input wire o_fl_dq_oe_n,
	input wire o_fl_ce_n,
	input wire o_fl_oe_n,
	input wire o_fl_we_n,
	input wire o_fl_rst_n
);
	reg [7:0] rlo_q; // cycles spent with the flash reset pin low
	wire take = i_req && !o_busy; // request seen while idle
	// length of the reset pulse, cleared whenever the pin is high
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) rlo_q <= 8'h00;
		else rlo_q <= o_fl_rst_n ? 8'h00 : rlo_q + 8'h01;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	property p_wr_pins;
		!o_fl_we_n |-> !o_fl_ce_n && o_fl_oe_n && o_fl_rst_n && !o_fl_dq_oe_n;
	endproperty
	a_wr_pins: assert property (p_wr_pins) else $error("bad write pins");
	property p_wr_width;
		$fell(o_fl_we_n) |=> !o_fl_we_n ##1 o_fl_we_n;
	endproperty
	a_wr_width: assert property (p_wr_width) else $error("we width");
	property p_rd_pins;
		!o_fl_oe_n |-> o_fl_we_n && o_fl_dq_oe_n && !o_fl_ce_n;
	endproperty
	a_rd_pins: assert property (p_rd_pins) else $error("bad read pins");
	property p_rst_width;
		$rose(o_fl_rst_n) |-> rlo_q >= 8'h19;
	endproperty
	a_rst_width: assert property (p_rst_width) else $error("short rst");
	property p_rst_quiet;
		!o_fl_rst_n |-> o_fl_we_n && o_fl_oe_n;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("strobe in rst");
	property p_susp_ref;
		take && i_op == `FNC_OP_SUSP && !o_erase_active |=> o_done && o_err;
	endproperty
	a_susp_ref: assert property (p_susp_ref) else $error("suspend taken");
	property p_res_ref;
		take && i_op == `FNC_OP_RESUME && !o_erase_suspended |=> o_done && o_err;
	endproperty
	a_res_ref: assert property (p_res_ref) else $error("resume taken");
	property p_chip_ref;
		take && i_op == `FNC_OP_CHIP && o_erase_suspended |=> o_done && o_err;
	endproperty
	a_chip_ref: assert property (p_chip_ref) else $error("erase taken");
	property p_susp_in;
		o_erase_suspended |-> o_erase_active;
	endproperty
	a_susp_in: assert property (p_susp_in) else $error("lone suspend");
	c_susp: cover property ($rose(o_erase_suspended));
	c_hwrst: cover property ($rose(o_fl_rst_n));
	c_query: cover property (take && i_op == `FNC_OP_QUERY);
endmodule // fnc_host_assertions
bind fnc_host fnc_host_assertions i_fnc_host_assertions (.i_clk(i_clk),
	.i_nrst(i_nrst), .i_req(i_req), .i_op(i_op), .o_busy(o_busy),
	.o_done(o_done), .o_err(o_err), .o_erase_active(o_erase_active),
	.o_erase_suspended(o_erase_suspended), .o_fl_dq_oe_n(o_fl_dq_oe_n),
	.o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n),
	.o_fl_rst_n(o_fl_rst_n));

// ==== fnc_flash_model.sv ====
// behavioural flash device that answers the host on its pins
`timescale 1ns/1ps
module fnc_flash_model #(
	parameter [7:0] MAKER_CODE = 8'h3c, // arbitrary value
	parameter [7:0] DEVICE_CODE = 8'h4d // arbitrary value
) (
	input wire [20:0] i_addr,
	input wire [7:0] i_dq,
	input wire i_ce_n,
	input wire i_oe_n,
	input wire i_we_n,
	input wire i_rst_n,
	input wire i_stuck, // program never ends and raises the timeout flag
	output wire [7:0] o_dq,
	output wire o_ready_busy
);
	// extended query bytes from 40h up
	localparam [103:0] QTAB = {8'h50, 8'h52, 8'h49, 8'h31, 8'h30,
		8'h01, 8'h02, 8'h01, 8'h01, 8'h04,
		8'h00, 8'h00, 8'h00};
	reg [7:0] mem [0:255]; // small window of the array
	reg [7:0] rd; // byte driven on a read
	reg [7:0] last_q; // released bus shows its inverse
	reg [1:0] mode_q; // 0 array, 1 identifier, 2 query
	reg [2:0] step_q; // place in the unlock sequence
	reg rb_q, susp_q, erase_q, stuck_q;
	time t_end;
	integer i;
	// back to array read with nothing running
	task clear;
		begin
			{mode_q, step_q, susp_q, erase_q, stuck_q} = 8'h00;
			rb_q = 1'b1;
		end
	endtask
	initial begin
		for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
		last_q = 8'h00;
		t_end = 0;
		clear;
	end
	always @(negedge i_rst_n) clear;
	// command decoder, latched on the rising write strobe
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_rst_n) begin
			if (erase_q && !susp_q && i_dq == 8'hb0) begin
				susp_q = 1'b1;
				rb_q <= #200 1'b1; // suspend takes effect after a latency
			end else if (susp_q && i_dq == 8'h30) begin
				susp_q = 1'b0;
				rb_q = 1'b0;
				t_end = $time + 2000;
			end else if (i_dq == 8'hf0) clear;
			else if (step_q == 3'h0 && i_dq == 8'h98) mode_q = 2'h2;
			else if (step_q == 3'h6) begin
				mem[i_addr[7:0]] = mem[i_addr[7:0]] & i_dq;
				{step_q, rb_q, stuck_q} = {4'h0, i_stuck};
				t_end = $time + 400;
			end else if (step_q == 3'h0 && i_dq == 8'haa) step_q = 3'h1;
			else if (step_q == 3'h1 && i_dq == 8'h55) step_q = 3'h2;
			else if (step_q == 3'h2 && i_dq == 8'h90) {mode_q, step_q} = 5'h08;
			else if (step_q == 3'h2 && i_dq == 8'ha0) step_q = 3'h6;
			else if (step_q == 3'h2 && i_dq == 8'h80) step_q = 3'h3;
			else if (step_q == 3'h3 && i_dq == 8'haa) step_q = 3'h4;
			else if (step_q == 3'h4 && i_dq == 8'h55) step_q = 3'h5;
			else if (step_q == 3'h5 && (i_dq == 8'h10 || i_dq == 8'h30)) begin
				for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
				{step_q, rb_q, erase_q} = {4'h0, i_dq == 8'h30};
				t_end = $time + 2000;
			end else {mode_q, step_q} = 5'h00;
		end
	end
	// embedded operation ends once its time is up
	always #20 begin
		if (!rb_q && !susp_q && !stuck_q && $time >= t_end) begin
			rb_q = 1'b1;
			erase_q = 1'b0;
		end
	end
	// read data by mode; status with the timeout flag while busy
	always_comb begin
		if (!rb_q && !susp_q) rd = {2'b00, stuck_q, 5'h00};
		else if (mode_q == 2'h1 && i_addr[1:0] == 2'h2)
			rd = {7'h00, i_addr[16]};
		else if (mode_q == 2'h1)
			rd = i_addr[0] ? DEVICE_CODE : MAKER_CODE;
		else if (mode_q == 2'h2 && i_addr[7:0] >= 8'h40 && i_addr[7:0] <= 8'h4c)
			rd = QTAB[(76 - i_addr[7:0]) * 8 +: 8];
		else if (mode_q == 2'h2) rd = 8'h00;
		else rd = mem[i_addr[7:0]];
	end
	always @(posedge i_oe_n) last_q = rd;
	assign o_dq = (!i_ce_n && !i_oe_n && i_rst_n) ? rd : ~last_q;
	assign o_ready_busy = rb_q;
endmodule // fnc_flash_model

// ==== test_fnc_host.sv ====
// self-checking bench: flash host driving the device model
`timescale 1ns/1ps
`include "fnc_consts.vh"
module test_fnc_host;
	localparam [7:0] MAKER = 8'h3c; // arbitrary value
	localparam [7:0] DEVICE = 8'h4d; // arbitrary value
	localparam [103:0] QTAB = {8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h01,
		8'h02, 8'h01, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00};
	reg i_clk = 1'b0, i_nrst = 1'b0, i_req = 1'b0, stuck = 1'b0;
	reg [3:0] i_op = 4'h0;
	reg [20:0] i_addr = 21'h000000;
	reg [7:0] i_data = 8'h00;
	wire o_busy, o_done, o_err, o_erase_active, o_erase_suspended;
	wire [7:0] o_rdata, dq_out, mdl_dq, fl_dq;
	wire [20:0] fl_addr;
	wire dq_oe_n, ce_n, oe_n, we_n, fl_rst_n, rb;
	integer n_fail = 0, num_checks = 0, k;
	assign fl_dq = dq_oe_n ? mdl_dq : dq_out; // host owns dq while enabled
	fnc_host i_fnc_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req),
		.i_op(i_op), .i_addr(i_addr), .i_data(i_data), .o_busy(o_busy),
		.o_done(o_done), .o_err(o_err), .o_rdata(o_rdata),
		.o_erase_active(o_erase_active), .o_erase_suspended(o_erase_suspended),
		.o_fl_addr(fl_addr), .o_fl_dq_out(dq_out), .o_fl_dq_oe_n(dq_oe_n),
		.i_fl_dq(fl_dq), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n), .o_fl_we_n(we_n),
		.o_fl_rst_n(fl_rst_n), .i_fl_ready_busy(rb));
	fnc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
		i_fnc_flash_model (.i_addr(fl_addr), .i_dq(fl_dq), .i_ce_n(ce_n),
		.i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(fl_rst_n), .i_stuck(stuck),
		.o_dq(mdl_dq), .o_ready_busy(rb));
	initial forever #10 i_clk = ~i_clk;
	// compare one byte or flag
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0t saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	// one request pulse, then a bounded wait for done
	task run(input [3:0] op, input [20:0] a, input [7:0] d);
		integer n;
		begin
			@(negedge i_clk);
			{i_op, i_addr, i_data, i_req} = {op, a, d, 1'b1};
			@(negedge i_clk);
			i_req = 1'b0;
			for (n = 0; o_done !== 1'b1 && n < 3000; n = n + 1) @(negedge i_clk);
			chk(o_done, 8'h01);
			chk(o_busy, 8'h00);
		end
	endtask
	task t_prog;
		begin
			run(`FNC_OP_READ, 21'h000003, 8'h00);
			chk(o_rdata, 8'hff);
			run(`FNC_OP_PROG, 21'h000003, 8'h5a);
			chk(o_err, 8'h00);
			run(`FNC_OP_READ, 21'h000003, 8'h00);
			chk(o_rdata, 8'h5a);
		end
	endtask
	task t_ident;
		begin
			run(`FNC_OP_IDENT, 21'h1ffffc, 8'h00);
			chk(o_rdata, MAKER);
			run(`FNC_OP_IDENT, 21'h1ffffd, 8'h00);
			chk(o_rdata, DEVICE);
			for (k = 0; k < 32; k = k + 9) begin
				run(`FNC_OP_PROT, {k[4:0], 16'h0000}, 8'h00);
				chk(o_rdata, {7'h00, k[0]});
			end
			run(`FNC_OP_READ, 21'h000003, 8'h00);
			chk(o_rdata, 8'h5a);
		end
	endtask
	task t_query;
		begin
			for (k = 8'h40; k <= 8'h4c; k = k + 1) begin
				run(`FNC_OP_QUERY, k[20:0], 8'h00);
				chk(o_rdata, QTAB[(76 - k) * 8 +: 8]);
			end
			run(`FNC_OP_QUERY, 21'h000045, 8'h00);
			chk(o_rdata, 8'h01);
			run(`FNC_OP_READ, 21'h000003, 8'h00);
			chk(o_rdata, 8'h5a);
		end
	endtask
	task t_erase;
		begin
			run(`FNC_OP_CHIP, 21'h000000, 8'h00);
			run(`FNC_OP_READ, 21'h000003, 8'h00);
			chk(o_rdata, 8'hff);
			run(`FNC_OP_SECT, 21'h000000, 8'h00);
			chk(o_erase_active, 8'h01);
			run(`FNC_OP_PROG, 21'h000003, 8'h00);
			chk(o_err, 8'h01);
			run(`FNC_OP_SUSP, 21'h000000, 8'h00);
			chk(o_erase_suspended, 8'h01);
			run(`FNC_OP_CHIP, 21'h000000, 8'h00);
			chk(o_err, 8'h01);
			run(`FNC_OP_RESUME, 21'h000000, 8'h00);
			chk({o_erase_active, o_erase_suspended}, 8'h02);
			for (k = 0; o_erase_active === 1'b1 && k < 500; k = k + 1)
				@(negedge i_clk);
			chk(o_erase_active, 8'h00);
		end
	endtask
	task t_refuse;
		begin
			run(4'hb, 21'h000000, 8'h00);
			chk(o_err, 8'h01);
			run(`FNC_OP_SUSP, 21'h000000, 8'h00);
			chk(o_err, 8'h01);
			run(`FNC_OP_RESUME, 21'h000000, 8'h00);
			chk(o_err, 8'h01);
		end
	endtask
	// timeout abort, then a hardware reset that cuts a running erase
	task t_fault;
		begin
			stuck = 1'b1;
			run(`FNC_OP_PROG, 21'h000007, 8'h00);
			chk(o_err, 8'h01);
			stuck = 1'b0;
			run(`FNC_OP_SECT, 21'h000000, 8'h00);
			chk(o_erase_active, 8'h01);
			run(`FNC_OP_HWRST, 21'h000000, 8'h00);
			chk({o_err, o_erase_active}, 8'h00);
			run(`FNC_OP_READ, 21'h000007, 8'h00);
			chk(o_err, 8'h00);
			chk(o_rdata, 8'hff);
		end
	endtask
	task end_of_test;
		begin
			if (n_fail == 0 && num_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		#400000;
		n_fail = n_fail + 1;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		@(negedge i_clk);
		i_nrst = 1'b1;
		repeat (4) @(negedge i_clk);
		t_prog;
		t_ident;
		t_query;
		t_erase;
		t_refuse;
		t_fault;
		end_of_test;
	end
endmodule // test_fnc_host
